// file: logic/dual_channel_pulse_output_ctrl.sv
// dual channel pulse output: control/feedback registers and per-channel sequence logic
// Behaviour
// - control word meaning depends on channel mode
// - factor byte scales start delay or period
// - start delay is factor times 0.1 times configured
// - period is factor times 0.1 times configured
// - single pulse holds output for word time
// - modulation duty follows the control word
// - train emits exactly word-count pulses
// - delay mode delays input falling edge
// - control bit 1 selects direct output
// - direct output level follows control bit 2
// - enable rising edge starts the sequence
// - clearing enable aborts the running sequence
// - shortened length or count raises pulse error
// - running flag covers single pulse duration
// - acknowledge flag mirrors the seen enable
// - status shows input and output levels
`default_nettype none
module dual_channel_pulse_output_ctrl #(
    parameter int          CHANNELS    = 2,
    parameter int          TICK_CYCLES = pulse_out_pkg::TICK_CYCLES,
    parameter logic [15:0] ON_DELAY    = pulse_out_pkg::ON_DELAY_DEFAULT,
    parameter logic [15:0] PERIOD      = pulse_out_pkg::PERIOD_DEFAULT
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_word_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic [3:0]  channel_mode_in,
    input  wire logic [1:0]  channel_input_pin_in,
    input  wire logic [1:0]  supply_short_flag_in,
    input  wire logic [1:0]  config_error_flag_in,
    output logic      [1:0]  channel_output_pin_out
);
    // ****************************************
    // time base tick divider
    // ****************************************
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0] tick_cnt_ff;
    logic          tick;

    assign tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_cnt_ff <= '0;
        end else if (tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TW'(1);
        end
    end

    // scaled time = factor * 0.1 * configured, in ticks
    function automatic logic [23:0] scale_time(input logic [7:0] factor, input logic [15:0] base);
        logic [23:0] prod;
        prod = 24'(factor) * 24'(base);
        return 24'(prod / 24'h00000a);
    endfunction

    // byte address of a channel register, channels one stride apart
    function automatic logic [2:0] ch_addr(input int c, input logic [2:0] offs);
        return 3'(c) * pulse_out_pkg::CH_STRIDE + offs;
    endfunction

    // ****************************************
    // register file
    // ****************************************
    pulse_out_pkg::ch_ctrl_t   ctrl_ff [CHANNELS];
    pulse_out_pkg::ch_status_t status  [CHANNELS];

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int c = 0; c < CHANNELS; c++) begin
                ctrl_ff[c].value  <= pulse_out_pkg::VALUE_RESET;
                ctrl_ff[c].ctrl   <= pulse_out_pkg::CTRL_RESET;
                ctrl_ff[c].factor <= pulse_out_pkg::FACTOR_RESET;
            end
        end else if (reg_wr_in) begin
            for (int c = 0; c < CHANNELS; c++) begin
                // channel c sits c*4 bytes up
                if (reg_word_in && reg_addr_in == ch_addr(c, pulse_out_pkg::CH0_VALUE_OFFS)) begin
                    ctrl_ff[c].value <= reg_wdata_in;
                end
                if (!reg_word_in && reg_addr_in == ch_addr(c, pulse_out_pkg::CH0_CTRL_OFFS)) begin
                    ctrl_ff[c].ctrl <= reg_wdata_in[7:0] & 8'h07;
                end
                if (!reg_word_in && reg_addr_in == ch_addr(c, pulse_out_pkg::CH0_FACTOR_OFFS)) begin
                    ctrl_ff[c].factor <= reg_wdata_in[7:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == pulse_out_pkg::CH0_STATUS_OFFS) begin
            reg_rdata_out <= status[0];
        end else if (reg_addr_in == pulse_out_pkg::CH1_STATUS_OFFS) begin
            reg_rdata_out <= status[1];
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ****************************************
    // channel sequence logic, one copy per channel
    // ****************************************
    for (genvar g = 0; g < CHANNELS; g++) begin : gen_ch
        pulse_out_pkg::out_mode_t mode;
        pulse_out_pkg::ch_state_t state_ff;
        logic        run_req;
        logic        run_prev_ff;
        logic        in_prev_ff;
        logic        seq_out_ff;
        logic        out_ff;
        logic        running_ff;
        logic        pulse_err_ff;
        logic [23:0] timer_ff;
        logic [23:0] period_ff;
        logic [23:0] phase_ff;
        logic [15:0] done_ff;
        logic [23:0] cur_period;
        logic [23:0] high_time;
        logic        start;

        assign mode    = pulse_out_pkg::out_mode_t'(channel_mode_in[2*g +: 2]);
        assign run_req = ctrl_ff[g].ctrl[pulse_out_pkg::CTRL_RUN_BIT];
        assign start   = run_req && !run_prev_ff;
        // modulation follows the factor live, train uses the latched period
        assign cur_period = (mode == pulse_out_pkg::MODE_PWM) ? scale_time(ctrl_ff[g].factor, PERIOD) : period_ff;
        // duty in per mille of the period
        assign high_time = 24'((40'(cur_period) * 40'(ctrl_ff[g].value)) / 40'(pulse_out_pkg::DUTY_FULL_SCALE));

        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                run_prev_ff <= 1'b0;
                in_prev_ff  <= 1'b0;
            end else begin
                run_prev_ff <= run_req;
                in_prev_ff  <= channel_input_pin_in[g];
            end
        end

        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                state_ff     <= pulse_out_pkg::ST_IDLE;
                timer_ff     <= '0;
                period_ff    <= '0;
                phase_ff     <= '0;
                done_ff      <= '0;
                seq_out_ff   <= 1'b0;
                running_ff   <= 1'b0;
                pulse_err_ff <= 1'b0;
            end else if (!run_req) begin
                state_ff   <= pulse_out_pkg::ST_IDLE;
                seq_out_ff <= 1'b0;
                running_ff <= 1'b0;
            end else if (mode == pulse_out_pkg::MODE_DELAY) begin
                // input rising passes after scaled on-delay, falling after word ticks
                running_ff <= 1'b1;
                if (channel_input_pin_in[g] != in_prev_ff) begin
                    timer_ff <= channel_input_pin_in[g] ? scale_time(ctrl_ff[g].factor, ON_DELAY)
                                                        : 24'(ctrl_ff[g].value);
                    state_ff <= pulse_out_pkg::ST_START_WAIT;
                end else if (state_ff == pulse_out_pkg::ST_START_WAIT) begin
                    if (timer_ff == '0) begin
                        seq_out_ff <= channel_input_pin_in[g];
                        state_ff   <= pulse_out_pkg::ST_IDLE;
                    end else if (tick) begin
                        timer_ff <= timer_ff - 24'h000001;
                    end
                end
            end else if (start) begin
                // factor taken at sequence start
                state_ff     <= pulse_out_pkg::ST_START_WAIT;
                timer_ff     <= scale_time(ctrl_ff[g].factor, ON_DELAY);
                period_ff    <= scale_time(ctrl_ff[g].factor, PERIOD);
                running_ff   <= 1'b1;
                pulse_err_ff <= 1'b0;
                done_ff      <= '0;
                phase_ff     <= '0;
            end else begin
                unique case (state_ff)
                    pulse_out_pkg::ST_IDLE: begin
                        seq_out_ff <= 1'b0;
                    end
                    pulse_out_pkg::ST_START_WAIT: begin
                        if (timer_ff == '0) begin
                            state_ff <= pulse_out_pkg::ST_ACTIVE;
                        end else if (tick) begin
                            timer_ff <= timer_ff - 24'h000001;
                        end
                    end
                    pulse_out_pkg::ST_ACTIVE: begin
                        unique case (mode)
                            pulse_out_pkg::MODE_SINGLE: begin
                                // done_ff counts ticks of output time
                                if (ctrl_ff[g].value < done_ff) begin
                                    pulse_err_ff <= 1'b1;
                                    running_ff   <= 1'b0;
                                    seq_out_ff   <= 1'b0;
                                    state_ff     <= pulse_out_pkg::ST_IDLE;
                                end else if (done_ff == ctrl_ff[g].value) begin
                                    running_ff <= 1'b0;
                                    seq_out_ff <= 1'b0;
                                    state_ff   <= pulse_out_pkg::ST_IDLE;
                                end else begin
                                    seq_out_ff <= 1'b1;
                                    if (tick) begin
                                        done_ff <= done_ff + 16'h0001;
                                    end
                                end
                            end
                            pulse_out_pkg::MODE_PWM: begin
                                seq_out_ff <= (phase_ff < high_time);
                                if (tick) begin
                                    phase_ff <= (phase_ff + 24'h000001 >= cur_period) ? '0 : phase_ff + 24'h000001;
                                end
                            end
                            default: begin
                                // train: done_ff counts finished pulses, half-period high
                                if (ctrl_ff[g].value < done_ff) begin
                                    pulse_err_ff <= 1'b1;
                                    running_ff   <= 1'b0;
                                    seq_out_ff   <= 1'b0;
                                    state_ff     <= pulse_out_pkg::ST_IDLE;
                                end else if (done_ff == ctrl_ff[g].value) begin
                                    running_ff <= 1'b0;
                                    seq_out_ff <= 1'b0;
                                    state_ff   <= pulse_out_pkg::ST_IDLE;
                                end else begin
                                    seq_out_ff <= (phase_ff < (period_ff >> 1));
                                    if (tick) begin
                                        if (phase_ff + 24'h000001 >= period_ff) begin
                                            phase_ff <= '0;
                                            done_ff  <= done_ff + 16'h0001;
                                        end else begin
                                            phase_ff <= phase_ff + 24'h000001;
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                    default: begin
                        state_ff <= pulse_out_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        // direct control wins over the sequence
        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                out_ff <= 1'b0;
            end else if (ctrl_ff[g].ctrl[pulse_out_pkg::CTRL_DIRECT_BIT]) begin
                out_ff <= ctrl_ff[g].ctrl[pulse_out_pkg::CTRL_LEVEL_BIT];
            end else begin
                out_ff <= seq_out_ff;
            end
        end

        assign channel_output_pin_out[g] = out_ff;
        assign status[g] = '{supply_short: supply_short_flag_in[g],
                             out_short:    1'b0,
                             config_error: config_error_flag_in[g],
                             pulse_error:  pulse_err_ff,
                             run_ack:      run_req,
                             in_level:     channel_input_pin_in[g],
                             out_level:    out_ff,
                             running:      running_ff};
    end

endmodule
`default_nettype wire

// file: logic/pulse_out_pkg.sv
// package: register map, field positions, modes and timing constants of the dual pulse output block
`default_nettype none
package pulse_out_pkg;
    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [2:0] CH0_VALUE_OFFS  = 3'h0;
    localparam logic [2:0] CH0_STATUS_OFFS = 3'h0;
    localparam logic [2:0] CH0_CTRL_OFFS   = 3'h2;
    localparam logic [2:0] CH0_FACTOR_OFFS = 3'h3;
    localparam logic [2:0] CH1_VALUE_OFFS  = 3'h4;
    localparam logic [2:0] CH1_STATUS_OFFS = 3'h4;
    localparam logic [2:0] CH1_CTRL_OFFS   = 3'h6;
    localparam logic [2:0] CH1_FACTOR_OFFS = 3'h7;
    localparam logic [2:0] CH_STRIDE       = 3'h4;
    // ****************************************
    // control byte fields
    // ****************************************
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_DIRECT_BIT = 1;
    localparam int CTRL_LEVEL_BIT  = 2;
    // ****************************************
    // status byte fields
    // ****************************************
    localparam int STS_RUNNING_BIT = 0;
    localparam int STS_OUT_BIT     = 1;
    localparam int STS_IN_BIT      = 2;
    localparam int STS_ACK_BIT     = 3;
    localparam int STS_PULSE_ERR   = 4;
    localparam int STS_CFG_ERR     = 5;
    localparam int STS_OUT_SHORT   = 6;
    localparam int STS_SUPPLY_BIT  = 7;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] VALUE_RESET  = 16'h0000;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  FACTOR_RESET = 8'h0a;
    // ****************************************
    // timing: time base tick and default configured times (in ticks)
    // ****************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int TIME_BASE_NS    = 100_000;
    localparam int TICK_CYCLES     = TIME_BASE_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [15:0] ON_DELAY_DEFAULT = 16'h0000;
    localparam logic [15:0] PERIOD_DEFAULT   = 16'h4e20;
    localparam logic [15:0] DUTY_FULL_SCALE  = 16'h03e8;
    // ****************************************
    // modes and channel states
    // ****************************************
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_PWM,
        MODE_TRAIN,
        MODE_DELAY
    } out_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START_WAIT,
        ST_ACTIVE
    } ch_state_t;
    typedef struct packed {
        logic [15:0] value;
        logic [7:0]  ctrl;
        logic [7:0]  factor;
    } ch_ctrl_t;
    typedef struct packed {
        logic       supply_short;
        logic       out_short;
        logic       config_error;
        logic       pulse_error;
        logic       run_ack;
        logic       in_level;
        logic       out_level;
        logic       running;
    } ch_status_t;
endpackage
`default_nettype wire

// file: verification/pulse_out_ctrl_monitor.sv
// checker: port-level properties of the dual channel pulse output block
`default_nettype none
module pulse_out_ctrl_monitor (
    input wire logic        sys_clk_in,
    input wire logic        reset_in,
    input wire logic [2:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_word_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [1:0]  channel_input_pin_in,
    input wire logic [1:0]  supply_short_flag_in,
    input wire logic [1:0]  config_error_flag_in,
    input wire logic [1:0]  channel_output_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // shadow of the control bits as written
    // ****************************************
    logic [2:0] ctrl0_ff;
    logic [2:0] ctrl1_ff;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl0_ff <= 3'h0;
        end else if (reg_wr_in && !reg_word_in && reg_addr_in == pulse_out_pkg::CH0_CTRL_OFFS) begin
            ctrl0_ff <= reg_wdata_in[2:0];
        end
    end
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl1_ff <= 3'h0;
        end else if (reg_wr_in && !reg_word_in && reg_addr_in == pulse_out_pkg::CH1_CTRL_OFFS) begin
            ctrl1_ff <= reg_wdata_in[2:0];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    property p_direct(logic d, logic l, logic o);
        (d && $stable(l)) [*3] |-> o == l;
    endproperty
    a_direct_ch0: assert property (p_direct(ctrl0_ff[1], ctrl0_ff[2], channel_output_pin_out[0]))
        else $error("direct level missing on output 0");
    a_direct_ch1: assert property (p_direct(ctrl1_ff[1], ctrl1_ff[2], channel_output_pin_out[1]))
        else $error("direct level missing on output 1");
    a_ack_ch0: assert property ((reg_addr_in == 3'h0 && !reg_wr_in) [*3] |-> reg_rdata_out[3] == ctrl0_ff[0])
        else $error("enable acknowledge wrong on channel 0");
    a_ack_ch1: assert property ((reg_addr_in == 3'h4 && !reg_wr_in) [*3] |-> reg_rdata_out[3] == ctrl1_ff[0])
        else $error("enable acknowledge wrong on channel 1");
    a_stop_running: assert property ((reg_addr_in == 3'h0 && !ctrl0_ff[0]) [*4] |-> !reg_rdata_out[0])
        else $error("running flag set without enable");
    a_in_level: assert property ((reg_addr_in == 3'h0 && $stable(channel_input_pin_in[0])) [*5]
        |-> reg_rdata_out[2] == channel_input_pin_in[0])
        else $error("input level flag wrong");
    a_out_level: assert property ((reg_addr_in == 3'h0 && $stable(channel_output_pin_out[0])) [*3]
        |-> reg_rdata_out[1] == channel_output_pin_out[0])
        else $error("output level flag wrong");
    a_flags_ch1: assert property ((reg_addr_in == 3'h4 && $stable(supply_short_flag_in[1])
        && $stable(config_error_flag_in[1])) [*4]
        |-> reg_rdata_out[7:5] == {supply_short_flag_in[1], 1'b0, config_error_flag_in[1]})
        else $error("supply or config flag wrong on channel 1");
    a_unmapped_zero: assert property (reg_addr_in[1:0] != 2'b00 |=> reg_rdata_out == 8'h00)
        else $error("read data not zero off the status bytes");
    a_reset_idle: assert property ($fell(reset_in) |-> channel_output_pin_out == 2'b00 && reg_rdata_out == 8'h00)
        else $error("outputs not idle after reset");
    c_seq_pulse: cover property (channel_output_pin_out[0] && !ctrl0_ff[1]);
    c_direct: cover property (ctrl1_ff[1] && channel_output_pin_out[1]);
    c_pulse_err: cover property (reg_rdata_out[4]);
endmodule
bind dual_channel_pulse_output_ctrl pulse_out_ctrl_monitor i_pulse_out_ctrl_monitor (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_word_in(reg_word_in), .reg_rdata_out(reg_rdata_out),
    .channel_input_pin_in(channel_input_pin_in), .supply_short_flag_in(supply_short_flag_in),
    .config_error_flag_in(config_error_flag_in), .channel_output_pin_out(channel_output_pin_out));
`default_nettype wire

// file: verification/pulse_field_model.sv
// field-side model: drives the digital inputs, counts and times output pulses
`default_nettype none
module pulse_field_model (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clr_in,
    input  wire logic [1:0]  level_req_in,
    input  wire logic [1:0]  out_pins_in,
    output logic [1:0]       in_pins_out,
    output logic [1:0][15:0] rise_cnt_out,
    output logic [1:0][15:0] width_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]       prev_ff;
    logic [1:0][15:0] run_ff;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            in_pins_out  <= 2'h0;
            prev_ff      <= 2'h0;
            run_ff       <= '0;
            rise_cnt_out <= '0;
            width_out    <= '0;
        end else begin
            in_pins_out <= level_req_in;
            prev_ff     <= out_pins_in;
            for (int c = 0; c < 2; c++) begin
                if (clr_in) begin
                    rise_cnt_out[c] <= 16'h0000;
                end else if (out_pins_in[c] && !prev_ff[c]) begin
                    rise_cnt_out[c] <= rise_cnt_out[c] + 16'h0001;
                end
                run_ff[c] <= out_pins_in[c] ? run_ff[c] + 16'h0001 : 16'h0000;
                // width of the last high pulse, in clock cycles
                if (!out_pins_in[c] && prev_ff[c]) begin
                    width_out[c] <= run_ff[c];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/dual_channel_pulse_output_ctrl_tb.sv
// testbench: register-level sequences for the dual channel pulse output block
`default_nettype none
module dual_channel_pulse_output_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 4;
    logic sys_clk_in, reset_in, reg_wr_in, reg_word_in, clr;
    logic [2:0] reg_addr_in;
    logic [15:0] reg_wdata_in;
    logic [7:0] reg_rdata_out;
    logic [3:0] channel_mode_in;
    logic [1:0] in_pins, level_req, supply, cfg, out_pins;
    logic [1:0][15:0] rise_cnt, width;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    always #50 sys_clk_in = ~sys_clk_in;
    dual_channel_pulse_output_ctrl #(.TICK_CYCLES(TICK), .ON_DELAY(16'h0005), .PERIOD(16'h0014))
        i_dual_channel_pulse_output_ctrl (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_word_in(reg_word_in), .reg_rdata_out(reg_rdata_out),
        .channel_mode_in(channel_mode_in), .channel_input_pin_in(in_pins), .supply_short_flag_in(supply),
        .config_error_flag_in(cfg), .channel_output_pin_out(out_pins));
    pulse_field_model i_pulse_field_model (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .clr_in(clr),
        .level_req_in(level_req), .out_pins_in(out_pins), .in_pins_out(in_pins), .rise_cnt_out(rise_cnt),
        .width_out(width));
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic chk_near(input string name, input int exp, input int got, input int tol);
        n_tests++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic w);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_word_in <= w;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input string name, input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(name, {8'h00, exp}, {8'h00, reg_rdata_out & mask});
    endtask
    task automatic wait_out(input int ch, input logic lvl, input int max, output int cnt);
        cnt = 0;
        @(negedge sys_clk_in);
        while (out_pins[ch] !== lvl && cnt < max) begin
            @(negedge sys_clk_in);
            cnt++;
        end
    endtask
    task automatic restart(input logic [2:0] a);
        wr(a, 16'h0000, 1'b0);
        wr(a, 16'h0001, 1'b0);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        stop_test;
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        reset_in = 1'b1;
        {reg_wr_in, reg_word_in, clr, reg_addr_in, reg_wdata_in} = '0;
        {level_req, supply, cfg} = '0;
        channel_mode_in = {pulse_out_pkg::MODE_SINGLE, pulse_out_pkg::MODE_SINGLE};
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        rd("status 0 after reset", 3'h0, 8'hff, 8'h00);
        rd("unmapped read", 3'h2, 8'hff, 8'h00);
        wr(3'h6, 16'h0007, 1'b0);
        rd("ch1 ack and level", 3'h4, 8'h0a, 8'h0a);
        chk("direct outputs", 16'h0002, {14'h0, out_pins});
        wr(3'h6, 16'h0003, 1'b0);
        rd("ch1 direct low", 3'h4, 8'h02, 8'h00);
        wr(3'h6, 16'h0000, 1'b0);
        wr(3'h0, 16'd6, 1'b1);
        wr(3'h2, 16'h0001, 1'b0);
        wait_out(0, 1'b1, 200, n);
        chk_near("start delay", 5 * TICK, n, 3);
        rd("single running", 3'h0, 8'h0b, 8'h0b);
        wait_out(0, 1'b0, 200, n);
        @(negedge sys_clk_in);
        chk_near("pulse width", 6 * TICK, width[0], 1);
        rd("single done", 3'h0, 8'h01, 8'h00);
        wr(3'h3, 16'h0014, 1'b0);
        restart(3'h2);
        wait_out(0, 1'b1, 200, n);
        chk_near("scaled start delay", 10 * TICK, n, 3);
        wr(3'h2, 16'h0000, 1'b0);
        wait_out(0, 1'b0, 4, n);
        chk_near("abort", 1, n, 2);
        rd("abort stops running", 3'h0, 8'h01, 8'h00);
        wr(3'h3, 16'h000a, 1'b0);
        wr(3'h0, 16'd20, 1'b1);
        restart(3'h2);
        wait_out(0, 1'b1, 200, n);
        repeat (10 * TICK) @(posedge sys_clk_in);
        wr(3'h0, 16'd2, 1'b1);
        rd("pulse error", 3'h0, 8'h11, 8'h10);
        restart(3'h2);
        rd("pulse error cleared", 3'h0, 8'h10, 8'h00);
        wr(3'h2, 16'h0000, 1'b0);
        channel_mode_in <= {pulse_out_pkg::MODE_PWM, pulse_out_pkg::MODE_TRAIN};
        clr <= 1'b1;
        @(posedge sys_clk_in);
        clr <= 1'b0;
        wr(3'h3, 16'h0005, 1'b0);
        wr(3'h0, 16'd3, 1'b1);
        restart(3'h2);
        repeat (400) @(posedge sys_clk_in);
        chk("train count", 16'd3, rise_cnt[0]);
        chk_near("train high time", 5 * TICK, width[0], 1);
        wr(3'h7, 16'h000a, 1'b0);
        wr(3'h4, 16'd500, 1'b1);
        restart(3'h6);
        repeat (200) @(posedge sys_clk_in);
        chk_near("pwm high time", 10 * TICK, width[1], 1);
        wr(3'h7, 16'h0005, 1'b0);
        repeat (200) @(posedge sys_clk_in);
        chk_near("pwm rescaled", 5 * TICK, width[1], 1);
        wr(3'h6, 16'h0000, 1'b0);
        channel_mode_in <= {pulse_out_pkg::MODE_PWM, pulse_out_pkg::MODE_DELAY};
        wr(3'h3, 16'h000a, 1'b0);
        wr(3'h0, 16'd5, 1'b1);
        restart(3'h2);
        level_req[0] <= 1'b1;
        wait_out(0, 1'b1, 200, n);
        level_req[0] <= 1'b0;
        wait_out(0, 1'b0, 200, n);
        chk_near("off delay", 5 * TICK, n, 4);
        supply <= 2'b10;
        cfg <= 2'b10;
        level_req[1] <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rd("ch1 flags", 3'h4, 8'he4, 8'ha4);
        rd("ch0 flags", 3'h0, 8'he4, 8'h00);
        stop_test;
    end
endmodule
`default_nettype wire
